//--- rtl/amp_control_register_bank.sv
// control and identification registers of the amplifier behind the two-wire port
//
// Operation
// RULE1: four read-only identification bytes at offsets 0x00 to 0x03
// RULE2: power bit 7 enables automatic sleep, set after reset
// RULE3: power bit 5 keeps the thermal sensor off, set after reset
// RULE4: power bits 4,3,2 select mono, right off, left off; clear after reset
// RULE5: power register resets to 0xa1; bit 0 is master sleep
// RULE6: amp bit 7 enables converter low power, set after reset
// RULE7: amp bits 5 and 4 invert right and left outputs
// RULE8: amp bit 3 selects reduced-emission edge rate, set after reset
// RULE9: amp bits 1:0 select gain 13/16/19/21 dB, reset to 19 dB
// RULE10: amp register at 0x05 resets to 0x8a
// RULE11: converter register at 0x06 resets to 0x02; bit 7 immediate volume
// RULE12: converter bits 6 and 5 mute right and left, clear after reset
// RULE13: converter bit 4 puts the high-pass filter in path
// RULE14: sample rate field bits 2:0 holds codes 000 to 101 only
// RULE15: reserved bits read zero, identification writes are ignored
`timescale 1ns/10ps
`include "amp_ctrl_defines.svh"

module amp_control_register_bank
    import amp_ctrl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR      = 7'h10,  // bus address, arbitrary default
    parameter logic [7:0] VENDOR_CODE   = 8'h5a,  // value is arbitrary
    parameter logic [7:0] PART_CODE_LO  = 8'h3c,  // value is arbitrary
    parameter logic [7:0] PART_CODE_HI  = 8'h7e,  // value is arbitrary
    parameter logic [7:0] SILICON_VER   = 8'h02   // value is arbitrary
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe_n,
    output power_ctrl_t       power_ctrl,
    output ampdac_ctrl_t      ampdac_ctrl,
    output dac_ctrl_t         dac_ctrl
);

    localparam int CTRL_REGS  = 3;
    localparam int IDX_POWER  = 0;
    localparam int IDX_AMPDAC = 1;
    localparam int IDX_DAC    = 2;

    localparam logic [7:0] CTRL_OFF  [CTRL_REGS] = '{`AMP_OFF_POWER,
                                                     `AMP_OFF_AMPDAC,
                                                     `AMP_OFF_DAC};
    localparam logic [7:0] CTRL_RST  [CTRL_REGS] = '{`AMP_RST_POWER,
                                                     `AMP_RST_AMPDAC,
                                                     `AMP_RST_DAC};
    localparam logic [7:0] CTRL_MASK [CTRL_REGS] = '{`AMP_MASK_POWER,
                                                     `AMP_MASK_AMPDAC,
                                                     `AMP_MASK_DAC};

    // refuse a reserved bus address or an illegal reset rate code
    generate
        if (DEV_ADDR < `AMP_ADDR_MIN || DEV_ADDR > `AMP_ADDR_MAX) begin : g_bad_addr
            $error("device address lies in a reserved range");
        end
        if (CTRL_RST[IDX_DAC][`AMP_FS_MSB:`AMP_FS_LSB] > `AMP_FS_MAX) begin : g_bad_fs
            $error("reset sample rate code is not a legal one");
        end
    endgenerate

    line_events_t  ev;
    link_state_t   state_q;
    link_state_t   state_d;
    logic [3:0]    cnt_q;
    logic [3:0]    cnt_d;
    logic [7:0]    shift_q;
    logic [7:0]    shift_d;
    logic [7:0]    tx_q;
    logic [7:0]    tx_d;
    logic [7:0]    ptr_q;
    logic [7:0]    ptr_d;
    logic          ptr_phase_q;
    logic          ptr_phase_d;
    logic          rw_q;
    logic          rw_d;
    logic          master_ack_q;
    logic          master_ack_d;
    logic          sda_oe_n_q;
    logic          sda_oe_n_d;
    logic [7:0]    ctrl_q [CTRL_REGS];
    logic [7:0]    ctrl_d [CTRL_REGS];

    wire  [7:0]    rd_byte;
    wire           byte_done;
    wire           addr_match;
    wire           line_event;
    wire           wr_fire;
    wire           rx_bit;
    wire           ack_fall;
    wire           bit_fall;
    wire  [7:0]    shift_in;
    wire  [7:0]    tx_shift;
    wire           rd_msb_oe_n;

    // line sampling and edge detection
    line_sampler u_sampler (
        .clk    (clk),
        .rst    (rst),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .events (ev)
    );

    // read multiplexer over the whole map
    function automatic logic [7:0] read_mux(
        input logic [7:0] offset,
        input logic [7:0] pwr,
        input logic [7:0] amp,
        input logic [7:0] dac
    );
        logic [7:0] val;
        val = `AMP_READ_NONE;
        if (offset == `AMP_OFF_VENDOR) begin
            val = VENDOR_CODE;                              // [RULE1]
        end else if (offset == `AMP_OFF_DEVICE_LO) begin
            val = PART_CODE_LO;                             // [RULE1]
        end else if (offset == `AMP_OFF_DEVICE_HI) begin
            val = PART_CODE_HI;                             // [RULE1]
        end else if (offset == `AMP_OFF_REVISION) begin
            val = SILICON_VER;                              // [RULE1]
        end else if (offset == `AMP_OFF_POWER) begin
            val = pwr & `AMP_MASK_POWER;                    // [RULE15]
        end else if (offset == `AMP_OFF_AMPDAC) begin
            val = amp & `AMP_MASK_AMPDAC;                   // [RULE15]
        end else if (offset == `AMP_OFF_DAC) begin
            val = dac & `AMP_MASK_DAC;                      // [RULE15]
        end
        return val;
    endfunction : read_mux

    // merge a written byte into a control register
    function automatic logic [7:0] merge_write(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask,
        input logic       rate_field
    );
        logic [7:0] val;
        val = (old_val & ~mask) | (new_val & mask);         // [RULE15]
        if (rate_field && new_val[`AMP_FS_MSB:`AMP_FS_LSB] > `AMP_FS_MAX) begin
            val[`AMP_FS_MSB:`AMP_FS_LSB] = old_val[`AMP_FS_MSB:`AMP_FS_LSB]; // [RULE14]
        end
        return val;
    endfunction : merge_write

    // shared decodes for the slave sequencer
    assign rd_byte    = read_mux(ptr_q, ctrl_q[IDX_POWER], ctrl_q[IDX_AMPDAC], ctrl_q[IDX_DAC]);
    assign byte_done  = (cnt_q == `AMP_BITS_PER_BYTE);
    assign addr_match = (shift_q[7:1] == DEV_ADDR);
    assign line_event = ev.start | ev.stop;
    assign rx_bit     = ev.scl_rise & ~byte_done;
    assign wr_fire    = ev.scl_fall & byte_done & ~ptr_phase_q & ~line_event
                      & (state_q == st_wr_data);

    // clock-fall and shift decodes shared by the sequencer states
    assign ack_fall    = ev.scl_fall & byte_done;
    assign bit_fall    = ev.scl_fall & ~byte_done & (cnt_q != `AMP_BIT_CNT_ZERO);
    assign shift_in    = {shift_q[6:0], ev.sda};
    assign tx_shift    = {tx_q[6:0], 1'b0};
    assign rd_msb_oe_n = rd_byte[7];                        // released line sends a one

    // slave sequencer: sample on clock rise, drive on clock fall
    always_comb begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        shift_d      = shift_q;
        tx_d         = tx_q;
        ptr_d        = ptr_q;
        ptr_phase_d  = ptr_phase_q;
        rw_d         = rw_q;
        master_ack_d = master_ack_q;
        sda_oe_n_d   = sda_oe_n_q;
        if (ev.start) begin
            state_d     = st_addr;                          // repeated start restarts
            cnt_d       = `AMP_BIT_CNT_ZERO;
            ptr_phase_d = 1'b1;
            sda_oe_n_d  = 1'b1;
        end else if (ev.stop) begin
            state_d    = st_idle;
            sda_oe_n_d = 1'b1;
        end else begin
            case (state_q)
                st_idle: begin
                    sda_oe_n_d = 1'b1;
                end
                st_addr: begin
                    if (rx_bit) begin
                        shift_d = shift_in;
                        cnt_d   = cnt_q + `AMP_BIT_CNT_ONE;
                    end else if (ack_fall) begin
                        if (addr_match) begin
                            rw_d       = shift_q[`AMP_RW_BIT];
                            sda_oe_n_d = 1'b0;              // acknowledge address
                            state_d    = st_addr_ack;
                        end else begin
                            state_d    = st_idle;           // other slave addressed
                        end
                    end
                end
                st_addr_ack: begin
                    if (ev.scl_fall) begin
                        cnt_d = `AMP_BIT_CNT_ZERO;
                        if (rw_q) begin
                            tx_d       = rd_byte;
                            sda_oe_n_d = rd_msb_oe_n;
                            ptr_d      = ptr_q + `AMP_PTR_STEP;
                            state_d    = st_rd_data;
                        end else begin
                            sda_oe_n_d = 1'b1;
                            state_d    = st_wr_data;
                        end
                    end
                end
                st_wr_data: begin
                    if (rx_bit) begin
                        shift_d = shift_in;
                        cnt_d   = cnt_q + `AMP_BIT_CNT_ONE;
                    end else if (ack_fall) begin
                        sda_oe_n_d = 1'b0;                  // acknowledge every byte
                        state_d    = st_wr_ack;
                        if (ptr_phase_q) begin
                            ptr_d       = shift_q;          // first byte sets pointer
                            ptr_phase_d = 1'b0;
                        end else begin
                            ptr_d = ptr_q + `AMP_PTR_STEP;
                        end
                    end
                end
                st_wr_ack: begin
                    if (ev.scl_fall) begin
                        sda_oe_n_d = 1'b1;
                        cnt_d      = `AMP_BIT_CNT_ZERO;
                        state_d    = st_wr_data;
                    end
                end
                st_rd_data: begin
                    if (rx_bit) begin
                        cnt_d = cnt_q + `AMP_BIT_CNT_ONE;
                    end else if (ack_fall) begin
                        sda_oe_n_d = 1'b1;                  // free line for master ack
                        state_d    = st_rd_ack;
                    end else if (bit_fall) begin
                        sda_oe_n_d = tx_q[6];
                        tx_d       = tx_shift;
                    end
                end
                st_rd_ack: begin
                    if (ev.scl_rise) begin
                        master_ack_d = ~ev.sda;
                    end else if (ev.scl_fall) begin
                        if (master_ack_q) begin
                            cnt_d      = `AMP_BIT_CNT_ZERO;
                            tx_d       = rd_byte;
                            sda_oe_n_d = rd_msb_oe_n;
                            ptr_d      = ptr_q + `AMP_PTR_STEP;
                            state_d    = st_rd_data;
                        end else begin
                            state_d    = st_idle;           // master ended the read
                        end
                    end
                end
                default: begin
                    state_d    = st_idle;
                    sda_oe_n_d = 1'b1;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q      <= st_idle;
            cnt_q        <= `AMP_BIT_CNT_ZERO;
            shift_q      <= `AMP_BYTE_ZERO;
            tx_q         <= `AMP_BYTE_ZERO;
            ptr_q        <= `AMP_PTR_RESET;
            ptr_phase_q  <= 1'b1;
            rw_q         <= 1'b0;
            master_ack_q <= 1'b0;
            sda_oe_n_q   <= 1'b1;
        end else begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            shift_q      <= shift_d;
            tx_q         <= tx_d;
            ptr_q        <= ptr_d;
            ptr_phase_q  <= ptr_phase_d;
            rw_q         <= rw_d;
            master_ack_q <= master_ack_d;
            sda_oe_n_q   <= sda_oe_n_d;
        end
    end

    // open-drain data line: only ever pulls low
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_out <= `AMP_DRIVE_LOW;
        end else begin
            sda_out <= `AMP_DRIVE_LOW;
        end
    end
    assign sda_oe_n = sda_oe_n_q;

    // writable control registers, identification offsets never match
    generate
        for (genvar gi = 0; gi < CTRL_REGS; gi++) begin : g_ctrl
            // refuse a reset value with a reserved bit set
            if ((CTRL_RST[gi] & ~CTRL_MASK[gi]) != `AMP_BYTE_ZERO) begin : g_bad_rst
                $error("reset value sets a reserved bit");
            end
            wire hit = wr_fire & (ptr_q == CTRL_OFF[gi]);   // [RULE15]
            assign ctrl_d[gi] = hit ? merge_write(ctrl_q[gi], shift_q, CTRL_MASK[gi],
                                                  gi == IDX_DAC)
                                    : ctrl_q[gi];
            always_ff @(posedge clk) begin
                if (rst) begin
                    ctrl_q[gi] <= CTRL_RST[gi];             // [RULE5] [RULE10] [RULE11]
                end else begin
                    ctrl_q[gi] <= ctrl_d[gi];
                end
            end
        end
    endgenerate

    // power fields: auto sleep, thermal sensor, mono, channel off, master sleep
    assign power_ctrl  = power_ctrl_t'(ctrl_q[IDX_POWER]);  // [RULE2] [RULE3] [RULE4] [RULE5]

    // amplifier fields: low power, polarity, edge rate, gain
    assign ampdac_ctrl = ampdac_ctrl_t'(ctrl_q[IDX_AMPDAC]); // [RULE6] [RULE7] [RULE8] [RULE9]

    // converter fields: immediate volume, mutes, high-pass, sample rate
    assign dac_ctrl    = dac_ctrl_t'(ctrl_q[IDX_DAC]);      // [RULE11] [RULE12] [RULE13] [RULE14]

endmodule : amp_control_register_bank

//--- rtl/amp_ctrl_defines.svh
// register offsets, reset values, field positions and protocol constants of the control bank
`ifndef AMP_CTRL_DEFINES_SVH
`define AMP_CTRL_DEFINES_SVH

// register offsets on the two-wire control port
`define AMP_OFF_VENDOR      8'h00
`define AMP_OFF_DEVICE_LO   8'h01
`define AMP_OFF_DEVICE_HI   8'h02
`define AMP_OFF_REVISION    8'h03
`define AMP_OFF_POWER       8'h04
`define AMP_OFF_AMPDAC      8'h05
`define AMP_OFF_DAC         8'h06

// reset values of the writable registers
`define AMP_RST_POWER       8'ha1
`define AMP_RST_AMPDAC      8'h8a
`define AMP_RST_DAC         8'h02

// writable bits, reserved positions are zero
`define AMP_MASK_POWER      8'hbd
`define AMP_MASK_AMPDAC     8'hbb
`define AMP_MASK_DAC        8'hf7

// sample rate field position and largest legal code
`define AMP_FS_MSB          2
`define AMP_FS_LSB          0
`define AMP_FS_MAX          3'h5

// value read back from an unmapped offset
`define AMP_READ_NONE       8'h00

// two-wire protocol constants
`define AMP_BITS_PER_BYTE   4'h8
`define AMP_BIT_CNT_ZERO    4'h0
`define AMP_BIT_CNT_ONE     4'h1
`define AMP_PTR_STEP        8'h01
`define AMP_PTR_RESET       8'h00
`define AMP_BYTE_ZERO       8'h00
`define AMP_LINE_IDLE       1'b1
`define AMP_DRIVE_LOW       1'b0
`define AMP_RW_BIT          0
`define AMP_ADDR_MIN        7'h08
`define AMP_ADDR_MAX        7'h77

`endif

//--- rtl/amp_ctrl_pkg.sv
// types shared by the control bank and its line sampler
package amp_ctrl_pkg;

    // power control register layout
    typedef struct packed {
        logic       auto_sleep_enable;
        logic       rsvd6;
        logic       thermal_sensor_off;
        logic       mono_select;
        logic       right_channel_off;
        logic       left_channel_off;
        logic       rsvd1;
        logic       master_sleep;
    } power_ctrl_t;

    // amplifier and converter control register layout
    typedef struct packed {
        logic       converter_low_power;
        logic       rsvd6;
        logic       right_output_invert;
        logic       left_output_invert;
        logic       low_emi_edge;
        logic       rsvd2;
        logic [1:0] analog_gain_select;
    } ampdac_ctrl_t;

    // converter control register layout
    typedef struct packed {
        logic       immediate_volume;
        logic       right_mute;
        logic       left_mute;
        logic       highpass_enable;
        logic       rsvd3;
        logic [2:0] sample_rate_range;
    } dac_ctrl_t;

    // sampled line levels and events of the two-wire port
    typedef struct packed {
        logic       sda;
        logic       scl_rise;
        logic       scl_fall;
        logic       start;
        logic       stop;
    } line_events_t;

    // two-wire slave states
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wr_data,
        st_wr_ack,
        st_rd_data,
        st_rd_ack
    } link_state_t;

endpackage : amp_ctrl_pkg

//--- rtl/line_sampler.sv
// samples the two-wire port lines and flags clock edges, start and stop
`timescale 1ns/10ps
`include "amp_ctrl_defines.svh"

module line_sampler
    import amp_ctrl_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output line_events_t      events
);

    logic scl_q;
    logic scl_p_q;
    logic sda_q;
    logic sda_p_q;

    // two sample stages per line, idle high after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q   <= `AMP_LINE_IDLE;
            scl_p_q <= `AMP_LINE_IDLE;
            sda_q   <= `AMP_LINE_IDLE;
            sda_p_q <= `AMP_LINE_IDLE;
        end else begin
            scl_q   <= scl_in;
            scl_p_q <= scl_q;
            sda_q   <= sda_in;
            sda_p_q <= sda_q;
        end
    end

    // edges of the clock line, data changes while clock is high
    assign events.sda      = sda_q;
    assign events.scl_rise = scl_q & ~scl_p_q;
    assign events.scl_fall = ~scl_q & scl_p_q;
    assign events.start    = scl_q & scl_p_q & sda_p_q & ~sda_q;
    assign events.stop     = scl_q & scl_p_q & ~sda_p_q & sda_q;

endmodule : line_sampler

//--- verification/amp_control_register_bank_tb.sv
// self-checking bench for the amplifier control register bank
`timescale 1ns/10ps

module amp_control_register_bank_tb;
    import amp_ctrl_pkg::*;

    localparam logic [6:0] ADDR = 7'h10;
    localparam logic [7:0] VEN  = 8'h5a; // value is arbitrary
    localparam logic [7:0] PCL  = 8'h3c; // value is arbitrary
    localparam logic [7:0] PCH  = 8'h7e; // value is arbitrary
    localparam logic [7:0] SVR  = 8'h02; // value is arbitrary
    localparam int         NROWS = 18;
    // rows of offset, written value, expected readback
    localparam logic [23:0] ROWS [NROWS] = '{
        24'h04_00_00, 24'h04_ff_bd, 24'h04_a0_a0, 24'h05_00_00, 24'h05_ff_bb, 24'h05_01_01,
        24'h05_02_02, 24'h06_00_00, 24'h06_01_01, 24'h06_e3_e3, 24'h06_14_14, 24'h06_0d_05,
        24'h06_9e_95, 24'h06_ff_f5, 24'h00_ff_5a, 24'h03_00_02, 24'h01_11_3c, 24'h07_55_00};

    logic         clk;
    logic         rst;
    logic         scl_in;
    logic         sda_m;
    wire logic    sda_in;
    logic         sda_out;
    logic         sda_oe_n;
    power_ctrl_t  power_ctrl;
    ampdac_ctrl_t ampdac_ctrl;
    dac_ctrl_t    dac_ctrl;
    logic         got_ack;
    logic [7:0]   rd;
    logic [23:0]  row;
    int           err_count;
    int           checks;

    // open-drain wire resolved from bench and device
    assign sda_in = sda_m & (sda_oe_n | sda_out);

    amp_control_register_bank #(
        .DEV_ADDR     (ADDR),
        .VENDOR_CODE  (VEN),
        .PART_CODE_LO (PCL),
        .PART_CODE_HI (PCH),
        .SILICON_VER  (SVR)
    ) dut (
        .clk         (clk),
        .rst         (rst),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .sda_out     (sda_out),
        .sda_oe_n    (sda_oe_n),
        .power_ctrl  (power_ctrl),
        .ampdac_ctrl (ampdac_ctrl),
        .dac_ctrl    (dac_ctrl)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // one bit: data set in low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_m = b;
        tick(3);
        scl_in = 1'b1;
        tick(2);
        r = sda_in;
        tick(2);
        scl_in = 1'b0;
    endtask : bit_io

    task automatic start_c;
        tick(1);
        sda_m = 1'b1;
        tick(3);
        scl_in = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl_in = 1'b0;
    endtask : start_c

    task automatic stop_c;
        tick(1);
        sda_m = 1'b0;
        tick(3);
        scl_in = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask : stop_c

    task automatic wr_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        got_ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : rd_byte

    task automatic reg_wr(input logic [7:0] off, input logic [7:0] d);
        start_c();
        wr_byte({ADDR, 1'b0});
        wr_byte(off);
        wr_byte(d);
        stop_c();
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] off, output logic [7:0] d);
        start_c();
        wr_byte({ADDR, 1'b0});
        wr_byte(off);
        start_c();
        wr_byte({ADDR, 1'b1});
        rd_byte(d, 1'b1);
        stop_c();
    endtask : reg_rd

    task automatic chk_reset;
        check(power_ctrl, 8'ha1);
        check(ampdac_ctrl, 8'h8a);
        check(dac_ctrl, 8'h02);
        reg_rd(8'h02, rd);
        check(rd, PCH);
        reg_rd(8'h06, rd);
        check(rd, 8'h02);
    endtask : chk_reset

    // watchdog on the whole run
    initial begin
        #300_000; // about twice the length of all scenarios
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        conclude();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        scl_in = 1'b1;
        sda_m = 1'b1;
        got_ack = 1'b0;
        err_count = 0;
        checks = 0;
        tick(16);
        rst = 1'b0;
        tick(4);
        chk_reset();
        for (int i = 0; i < NROWS; i++) begin
            row = ROWS[i];
            reg_wr(row[23:16], row[15:8]);
            check({7'h0, got_ack}, 8'h01);
            reg_rd(row[23:16], rd);
            check(rd, row[7:0]);
            if (row[23:16] == 8'h04) check(power_ctrl, row[7:0]);
            if (row[23:16] == 8'h05) check(ampdac_ctrl, row[7:0]);
            if (row[23:16] == 8'h06) check(dac_ctrl, row[7:0]);
        end
        // burst write then burst read with auto-increment
        start_c();
        wr_byte({ADDR, 1'b0});
        wr_byte(8'h04);
        wr_byte(8'h1c);
        wr_byte(8'h30);
        wr_byte(8'h81);
        stop_c();
        check(power_ctrl, 8'h1c);
        check(ampdac_ctrl, 8'h30);
        check(dac_ctrl, 8'h81);
        start_c();
        wr_byte({ADDR, 1'b0});
        wr_byte(8'h03);
        start_c();
        wr_byte({ADDR, 1'b1});
        rd_byte(rd, 1'b0);
        check(rd, SVR);
        rd_byte(rd, 1'b0);
        check(rd, 8'h1c);
        rd_byte(rd, 1'b1);
        check(rd, 8'h30);
        stop_c();
        // other address is not acknowledged and writes nothing
        start_c();
        wr_byte({7'h11, 1'b0});
        check({7'h0, got_ack}, 8'h00);
        wr_byte(8'h04);
        wr_byte(8'h00);
        stop_c();
        check(power_ctrl, 8'h1c);
        // partial byte cut by stop writes nothing
        start_c();
        wr_byte({ADDR, 1'b0});
        wr_byte(8'h04);
        for (int i = 0; i < 4; i++) bit_io(1'b0, got_ack);
        stop_c();
        check(power_ctrl, 8'h1c);
        // second reset in mid-run
        rst = 1'b1;
        tick(16);
        rst = 1'b0;
        tick(4);
        chk_reset();
        conclude();
    end
endmodule : amp_control_register_bank_tb

bind amp_control_register_bank amp_ctrl_sva chk (
    .clk         (clk),
    .rst         (rst),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe_n    (sda_oe_n),
    .power_ctrl  (power_ctrl),
    .ampdac_ctrl (ampdac_ctrl),
    .dac_ctrl    (dac_ctrl)
);

//--- verification/amp_ctrl_sva.sv
// concurrent checks on the ports of the amplifier control register bank
`timescale 1ns/10ps

module amp_ctrl_sva
    import amp_ctrl_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         scl_in,
    input wire logic         sda_in,
    input wire logic         sda_out,
    input wire logic         sda_oe_n,
    input wire power_ctrl_t  power_ctrl,
    input wire ampdac_ctrl_t ampdac_ctrl,
    input wire dac_ctrl_t    dac_ctrl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // reset state of the writable registers and the data line
    AST_PWR_RST: assert property (disable iff (1'b0)
        rst |=> power_ctrl == 8'ha1 && sda_oe_n) else $error("power register reset wrong");
    AST_AMP_RST: assert property (disable iff (1'b0)
        rst |=> ampdac_ctrl == 8'h8a) else $error("amplifier register reset wrong");
    AST_DAC_RST: assert property (disable iff (1'b0)
        rst |=> dac_ctrl == 8'h02) else $error("converter register reset wrong");

    // reserved positions never hold a one, sample rate code stays legal
    AST_PWR_RSVD: assert property ({power_ctrl.rsvd6, power_ctrl.rsvd1} == 2'h0)
        else $error("power reserved bit set");
    AST_AMP_RSVD: assert property ({ampdac_ctrl.rsvd6, ampdac_ctrl.rsvd2} == 2'h0)
        else $error("amplifier reserved bit set");
    AST_DAC_RSVD: assert property (dac_ctrl.rsvd3 == 1'b0)
        else $error("converter reserved bit set");
    AST_FS_LEGAL: assert property (dac_ctrl.sample_rate_range <= 3'h5)
        else $error("sample rate code out of range");

    // updates and line changes only while the clock line is low
    AST_CTRL_AT_LOW: assert property ($changed({power_ctrl, ampdac_ctrl, dac_ctrl})
        |-> !scl_in && !$past(scl_in, 2) && $past(scl_in, 3))
        else $error("register update outside low phase");
    AST_OE_AT_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data line changed while clock high");
    AST_SDA_ZERO: assert property (sda_out == 1'b0)
        else $error("data drive value not low");

    // main scenarios reached
    CV_AWAKE: cover property (power_ctrl.master_sleep == 1'b0);
    CV_DRIVE: cover property ($fell(sda_oe_n));
    CV_FS_TOP: cover property (dac_ctrl.sample_rate_range == 3'h5);
    CV_PULL_LOW: cover property (!sda_oe_n && !sda_in);
endmodule : amp_ctrl_sva
